//--- src/vdl_pkg.sv
// Package for the DC link voltage limiter: register map, field layout and sizes.
// Assumes a single 100 MHz clock domain and a plain strobe register port.
package vdl_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_CONFIG    = 8'h00;  // Mode code.
    localparam logic [7:0] OFS_UPPER_THR = 8'h04;  // Upper voltage threshold.
    localparam logic [7:0] OFS_LOWER_THR = 8'h08;  // Lower voltage threshold.
    localparam logic [7:0] OFS_GAIN      = 8'h0C;  // Proportional gain.
    localparam logic [7:0] OFS_TQ_OFFSET = 8'h10;  // Torque limit offset.
    localparam logic [7:0] OFS_STATUS    = 8'h14;  // Status word, read only.
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;  // Sticky events, write one clears.
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h1C;  // Interrupt enables.
    localparam logic [7:0] OFS_VDC       = 8'h20;  // Last measured voltage, read only.

    // Data widths.
    localparam int VW = 16;  // Voltage in volts, unsigned.
    localparam int TW = 16;  // Torque, signed.
    localparam int GW = 16;  // Gain, unsigned Q8.8.
    localparam int GF = 8;   // Fraction bits of the gain.

    // Status word bit positions.
    localparam int ST_OV_ACT = 14;  // Overvoltage limiter intervening.
    localparam int ST_UV_ACT = 15;  // Undervoltage buffer intervening.

    // Interrupt event bit positions.
    localparam int EV_UV_TRIP = 0;
    localparam int EV_OV_TRIP = 1;
    localparam int EV_UV_ACT  = 2;
    localparam int EV_OV_ACT  = 3;
    localparam int EV_N       = 4;

    // Reset values.
    localparam logic [3:0]    RST_CONFIG = 4'h0;
    localparam logic [VW-1:0] RST_UPPER  = 16'h02BC;   // 700 V.
    localparam logic [VW-1:0] RST_LOWER  = 16'h01C2;   // 450 V.
    localparam logic [GW-1:0] RST_GAIN   = 16'h0100;   // Unity.
    localparam logic [TW-1:0] RST_TQOFS  = 16'h0000;

    // Decoded mode for one configuration code.
    typedef struct packed {
        logic ov_ctrl;    // Overvoltage limiter enabled.
        logic uv_ctrl;    // Undervoltage buffer enabled.
        logic no_accel;   // Limiter may not accelerate.
        logic no_brake;   // Buffer may not brake actively.
        logic ov_mon;     // Overvoltage trip enabled.
        logic uv_mon;     // Undervoltage trip enabled.
    } vdl_mode_t;

    // Torque limit pair.
    typedef struct packed {
        logic signed [TW-1:0] upper;
        logic signed [TW-1:0] lower;
    } vdl_tlim_t;

endpackage : vdl_pkg

//--- src/vdl_limiter.sv
// DC link voltage limiter for one drive: proportional limit shifting, trips, status and IRQ.
// Assumes vdc arrives on clk each control cycle marked by ctl_tick; limits are on clk too.
// Thresholds are in volts, the gain in Q8.8 and the torque limits signed.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module vdl_limiter
    import vdl_pkg::*;
(
    // Clock and reset.
    input  wire  logic                 clk,
    input  wire  logic                 rst_n,
    // Measurement and control cycle.
    input  wire  logic                 ctl_tick,
    input  wire  logic [VW-1:0]        vdc,
    // Torque limits in and out.
    input  wire  vdl_tlim_t            tlim_in,
    output var   vdl_tlim_t            tlim_out,
    // Faults and flags.
    output logic                       undervoltage_trip_fault,
    output logic                       overvoltage_trip_fault,
    output logic                       overvoltage_ctrl_active_flag,
    output logic                       undervoltage_ctrl_active_flag,
    // Register port.
    input  wire  logic [7:0]           reg_addr,
    input  wire  logic [31:0]          reg_wdata,
    input  wire  logic                 reg_wr,
    input  wire  logic                 reg_rd,
    output logic [31:0]                reg_rdata,
    // Interrupt.
    output logic                       irq
);

    // Decode of the configuration code; unused codes disable everything.
    // Kept as a function so that every code's meaning sits in one table.
    function automatic vdl_mode_t decode_mode(input logic [3:0] c);
        vdl_mode_t m;
        m = '0;
        m.ov_ctrl  = (c == 4'h1) || (c == 4'h3) || (c == 4'h7) || (c == 4'h9);
        m.uv_ctrl  = (c == 4'h2) || (c == 4'h3) || (c == 4'h8) || (c == 4'h9);
        m.no_accel = (c == 4'h7) || (c == 4'h9);
        m.no_brake = (c == 4'h8) || (c == 4'h9);
        m.ov_mon   = (c == 4'h4) || (c == 4'h6);
        m.uv_mon   = (c == 4'h5) || (c == 4'h6);
        return m;
    endfunction

    // Saturate a 32-bit signed value to the torque width.
    // Without it a large correction would wrap a limit round to the opposite sign,
    // turning a cut in braking into full braking.
    function automatic logic signed [TW-1:0] sat_t(input logic signed [31:0] v);
        logic signed [31:0] hi;
        logic signed [31:0] lo;
        hi = 32'sh0000_7FFF;
        lo = -32'sh0000_8000;
        if (v > hi) begin
            sat_t = 16'sh7FFF;
        end else if (v < lo) begin
            sat_t = -16'sh8000;
        end else begin
            sat_t = v[TW-1:0];
        end
    endfunction

    // Configuration registers. A new threshold or gain acts from the next control
    // cycle on, so software may retune them while the drive runs; the offset acts
    // on the next clock.
    logic [3:0]           cfg_ff,   nxt_cfg;
    logic [VW-1:0]        upper_ff, nxt_upper;
    logic [VW-1:0]        lower_ff, nxt_lower;
    logic [GW-1:0]        gain_ff,  nxt_gain;
    logic signed [TW-1:0] tqofs_ff, nxt_tqofs;
    logic [EV_N-1:0]      ista_ff,  nxt_ista;   // Sticky events.
    logic [EV_N-1:0]      imsk_ff,  nxt_imsk;   // Interrupt mask.
    logic [31:0]          rdata_ff, nxt_rdata;  // Read data, one cycle after strobe.

    // Control state, updated on each control cycle.
    // Between ticks it holds, so flags and correction stand for a whole cycle.
    logic [VW-1:0]        vdc_ff,   nxt_vdc;    // Voltage seen in the last cycle.
    logic signed [TW-1:0] corr_ff,  nxt_corr;   // Signed correction to the limits.
    logic                 ovact_ff, nxt_ovact;
    logic                 uvact_ff, nxt_uvact;
    logic                 uvtrp_ff, nxt_uvtrp;
    logic                 ovtrp_ff, nxt_ovtrp;
    vdl_tlim_t            tlim_ff,  nxt_tlim;

    // Decoded mode, this cycle's events and the status word.
    vdl_mode_t            mode;
    logic [EV_N-1:0]      ev;                   // Rising events this cycle.
    logic [15:0]          status;

    // A new code acts from the next clock; unused codes leave every output idle.
    assign mode = decode_mode(cfg_ff);

    // Proportional control and monitoring, evaluated once per control cycle.
    // The product is formed in 32 bits: a 16-bit excess times a 16-bit gain only
    // overflows it for settings far outside any real DC link.
    always_comb begin
        logic signed [31:0] exc;
        logic signed [31:0] prod;
        exc       = '0;
        prod      = '0;
        nxt_vdc   = vdc_ff;
        nxt_corr  = corr_ff;
        nxt_ovact = ovact_ff;
        nxt_uvact = uvact_ff;
        nxt_uvtrp = uvtrp_ff;
        nxt_ovtrp = ovtrp_ff;
        if (ctl_tick) begin
            nxt_vdc   = vdc;
            nxt_ovact = 1'b0;
            nxt_uvact = 1'b0;
            nxt_corr  = '0;
            // Flags restart at each tick, so a flag stands only while the excess lasts.
            // Excess over the active threshold: positive above upper, negative below lower.
            // Reaching the upper threshold already counts, with an excess of zero.
            if (mode.ov_ctrl && (vdc >= upper_ff)) begin
                exc       = 32'(vdc) - 32'(upper_ff);
                nxt_ovact = 1'b1;
            end else if (mode.uv_ctrl && (vdc < lower_ff)) begin
                exc       = 32'(vdc) - 32'(lower_ff);
                nxt_uvact = 1'b1;
            end
            // Leaving the band on recovery clears the buffer automatically.
            prod     = (exc * $signed({16'h0000, gain_ff})) >>> GF;
            nxt_corr = sat_t(prod);
            // Trips latch until reset so the drive stays off; software sees them.
            // Only a reset clears them; the sticky event tells software which one fired.
            if (mode.uv_mon && (vdc < lower_ff)) begin
                nxt_uvtrp = 1'b1;
            end
            if (mode.ov_mon && (vdc >= upper_ff)) begin
                nxt_ovtrp = 1'b1;
            end
        end
    end

    // Torque limits follow the base limits every clock, shifted by the correction
    // of the last control cycle, so the drive path gains only one register of lag.
    always_comb begin
        logic signed [31:0] up;
        logic signed [31:0] lo;
        // Shift both limits by the correction: a positive correction cuts braking
        // and may push into motoring, a negative one forces braking.
        up = 32'(tlim_in.upper) + 32'(corr_ff);
        lo = 32'(tlim_in.lower) + 32'(corr_ff);
        // The clamps act only while their controller intervenes; at rest the
        // offset has no say and the base limits pass unchanged.
        if (uvact_ff && mode.no_brake && (up < 32'(tqofs_ff))) begin
            up = 32'(tqofs_ff);
        end
        if (ovact_ff && mode.no_accel && (lo > 32'(tqofs_ff))) begin
            lo = 32'(tqofs_ff);
        end
        nxt_tlim.upper = sat_t(up);
        nxt_tlim.lower = sat_t(lo);
    end

    // Events: rising edges of trips and of activity.
    // An intervention raises its event once, so a long dip does not repeat it.
    assign ev[EV_UV_TRIP] = nxt_uvtrp & ~uvtrp_ff;
    assign ev[EV_OV_TRIP] = nxt_ovtrp & ~ovtrp_ff;
    assign ev[EV_UV_ACT]  = nxt_uvact & ~uvact_ff;
    assign ev[EV_OV_ACT]  = nxt_ovact & ~ovact_ff;

    // Status word with activity flags at their fixed positions.
    // Every other bit reads zero; the flags mirror the registered activity, so the
    // word changes only at a control cycle.
    always_comb begin
        status            = '0;
        status[ST_OV_ACT] = ovact_ff;
        status[ST_UV_ACT] = uvact_ff;
    end

    // Register writes and reads; unmapped addresses read zero and ignore writes.
    // Writes to the status word and the measured voltage fall to the default
    // branch, so both stay read only whatever software sends.
    // Read data come from a register, so they stand only in the cycle after the strobe.
    always_comb begin
        nxt_cfg   = cfg_ff;
        nxt_upper = upper_ff;
        nxt_lower = lower_ff;
        nxt_gain  = gain_ff;
        nxt_tqofs = tqofs_ff;
        nxt_imsk  = imsk_ff;
        nxt_ista  = ista_ff;
        nxt_rdata = '0;
        if (reg_wr) begin
            case (reg_addr)
                OFS_CONFIG:    nxt_cfg   = reg_wdata[3:0];
                OFS_UPPER_THR: nxt_upper = reg_wdata[VW-1:0];
                OFS_LOWER_THR: nxt_lower = reg_wdata[VW-1:0];
                OFS_GAIN:      nxt_gain  = reg_wdata[GW-1:0];
                OFS_TQ_OFFSET: nxt_tqofs = reg_wdata[TW-1:0];
                OFS_IRQ_STAT:  nxt_ista  = ista_ff & ~reg_wdata[EV_N-1:0];
                OFS_IRQ_MASK:  nxt_imsk  = reg_wdata[EV_N-1:0];
                default:       nxt_cfg   = cfg_ff;
            endcase
        end
        // A new event wins over a clear in the same cycle.
        // Software therefore never loses an event that lands on its own clear.
        nxt_ista = nxt_ista | ev;
        // Reads have no side effect; even the sticky events need a write to clear.
        if (reg_rd) begin
            case (reg_addr)
                OFS_CONFIG:    nxt_rdata = {28'h000_0000, cfg_ff};
                OFS_UPPER_THR: nxt_rdata = {16'h0000, upper_ff};
                OFS_LOWER_THR: nxt_rdata = {16'h0000, lower_ff};
                OFS_GAIN:      nxt_rdata = {16'h0000, gain_ff};
                OFS_TQ_OFFSET: nxt_rdata = {16'h0000, tqofs_ff};
                OFS_STATUS:    nxt_rdata = {16'h0000, status};
                OFS_IRQ_STAT:  nxt_rdata = {28'h000_0000, ista_ff};
                OFS_IRQ_MASK:  nxt_rdata = {28'h000_0000, imsk_ff};
                OFS_VDC:       nxt_rdata = {16'h0000, vdc_ff};
                default:       nxt_rdata = '0;
            endcase
        end
    end

    // Register group: software settings, interrupt state and read data.
    // The reset is synchronous, so it acts only on a clock edge like every write.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cfg_ff   <= RST_CONFIG;
            upper_ff <= RST_UPPER;
            lower_ff <= RST_LOWER;
            gain_ff  <= RST_GAIN;
            tqofs_ff <= RST_TQOFS;
            ista_ff  <= '0;
            imsk_ff  <= '0;
            rdata_ff <= '0;
        end else begin
            cfg_ff   <= nxt_cfg;
            upper_ff <= nxt_upper;
            lower_ff <= nxt_lower;
            gain_ff  <= nxt_gain;
            tqofs_ff <= nxt_tqofs;
            ista_ff  <= nxt_ista;
            imsk_ff  <= nxt_imsk;
            rdata_ff <= nxt_rdata;
        end
    end

    // Control group: measured voltage, correction, activity flags and trips.
    // Reset drops every intervention, so the drive restarts with its own limits.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            vdc_ff   <= '0;
            corr_ff  <= '0;
            ovact_ff <= 1'b0;
            uvact_ff <= 1'b0;
            uvtrp_ff <= 1'b0;
            ovtrp_ff <= 1'b0;
        end else begin
            vdc_ff   <= nxt_vdc;
            corr_ff  <= nxt_corr;
            ovact_ff <= nxt_ovact;
            uvact_ff <= nxt_uvact;
            uvtrp_ff <= nxt_uvtrp;
            ovtrp_ff <= nxt_ovtrp;
        end
    end

    // Limit group: the corrected torque limits handed to the drive.
    // They read zero during reset, which holds the drive without torque.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tlim_ff <= '0;
        end else begin
            tlim_ff <= nxt_tlim;
        end
    end

    // Outputs straight from flip-flops, except the interrupt, a level gated from them.
    // The interrupt is a gate of flip-flops, so it cannot glitch, and it stays
    // high until software clears the event or masks it.
    assign tlim_out                      = tlim_ff;
    assign undervoltage_trip_fault       = uvtrp_ff;
    assign overvoltage_trip_fault        = ovtrp_ff;
    assign overvoltage_ctrl_active_flag  = ovact_ff;
    assign undervoltage_ctrl_active_flag = uvact_ff;
    assign reg_rdata                     = rdata_ff;
    assign irq                           = |(ista_ff & imsk_ff);

endmodule : vdl_limiter // vdl_limiter

`default_nettype wire

//--- sim/vdl_link_model.sv
// Model of the DC link measurement and the drive's base torque limits.
// Assumes the bench commands the link level; a control cycle is 4 clocks.
`timescale 1ns/1ns
`default_nettype none
module vdl_link_model
    import vdl_pkg::*;
(
    // Clock and reset.
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Commanded link voltage.
    input  wire logic [VW-1:0] level,
    // Measurement and limits.
    output logic               ctl_tick,
    output logic [VW-1:0]      vdc,
    output vdl_tlim_t          tlim_in
);
    logic [1:0] phase_ff;  // Position in the control cycle.
    // The measurement is refreshed every clock, so it is never stale at a tick.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
        vdc <= level;
    end
    assign ctl_tick = (phase_ff == 2'h3);
    // Small base limits, so that a correction can cross zero.
    assign tlim_in = '{upper: 16'h0014, lower: 16'hFFEC};
endmodule // vdl_link_model
`default_nettype wire

//--- sim/vdl_limiter_chk.sv
// Port checker for the DC link voltage limiter.
// Assumes the torque limit offset stays at its reset value.
`timescale 1ns/1ns
`default_nettype none
module vdl_limiter_chk
    import vdl_pkg::*;
(
    // Clock and reset.
    input wire logic          clk,
    input wire logic          rst_n,
    // Control path.
    input wire logic          ctl_tick,
    input wire logic [VW-1:0] vdc,
    input wire vdl_tlim_t     tlim_out,
    input wire logic          undervoltage_trip_fault,
    input wire logic          overvoltage_trip_fault,
    input wire logic          overvoltage_ctrl_active_flag,
    input wire logic          undervoltage_ctrl_active_flag,
    // Register writes.
    input wire logic [7:0]    reg_addr,
    input wire logic [31:0]   reg_wdata,
    input wire logic          reg_wr
);
    logic [3:0]    cfg_ff, nxt_cfg;  // Shadow of the mode code.
    logic [VW-1:0] up_ff, nxt_up;    // Shadow of the upper threshold.
    logic [VW-1:0] lo_ff, nxt_lo;    // Shadow of the lower threshold.
    logic          ov_act, uv_act, ov_mon, uv_mon;
    // Follow the writes so that expectations track the live settings.
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_up = up_ff;
        nxt_lo = lo_ff;
        if (reg_wr && reg_addr == OFS_CONFIG) nxt_cfg = reg_wdata[3:0];
        if (reg_wr && reg_addr == OFS_UPPER_THR) nxt_up = reg_wdata[VW-1:0];
        if (reg_wr && reg_addr == OFS_LOWER_THR) nxt_lo = reg_wdata[VW-1:0];
    end
    always_ff @(posedge clk) begin
        cfg_ff <= rst_n ? nxt_cfg : RST_CONFIG;
        up_ff <= rst_n ? nxt_up : RST_UPPER;
        lo_ff <= rst_n ? nxt_lo : RST_LOWER;
    end
    assign ov_act = vdc >= up_ff && cfg_ff inside {4'h1, 4'h3, 4'h7, 4'h9};
    assign uv_act = vdc < lo_ff && cfg_ff inside {4'h2, 4'h3, 4'h8, 4'h9};
    assign ov_mon = vdc >= up_ff && cfg_ff inside {4'h4, 4'h6};
    assign uv_mon = vdc < lo_ff && cfg_ff inside {4'h5, 4'h6};
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_ov_flag; ctl_tick |=> overvoltage_ctrl_active_flag == $past(ov_act); endproperty
    a_ov_flag: assert property (p_ov_flag) else $error("ov flag wrong");
    property p_uv_flag; ctl_tick |=> undervoltage_ctrl_active_flag == $past(uv_act); endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("uv flag wrong");
    property p_hold;
        !ctl_tick |=> $stable({overvoltage_ctrl_active_flag, undervoltage_ctrl_active_flag});
    endproperty
    a_hold: assert property (p_hold) else $error("flag moved off tick");
    property p_ov_trip; ctl_tick && ov_mon |=> overvoltage_trip_fault; endproperty
    a_ov_trip: assert property (p_ov_trip) else $error("ov trip missed");
    property p_ov_why; $rose(overvoltage_trip_fault) |-> $past(ctl_tick) && $past(ov_mon); endproperty
    a_ov_why: assert property (p_ov_why) else $error("ov trip uncaused");
    property p_uv_trip; ctl_tick && uv_mon |=> undervoltage_trip_fault; endproperty
    a_uv_trip: assert property (p_uv_trip) else $error("uv trip missed");
    property p_uv_keep; undervoltage_trip_fault |=> undervoltage_trip_fault; endproperty
    a_uv_keep: assert property (p_uv_keep) else $error("uv trip dropped");
    property p_up_min;
        undervoltage_ctrl_active_flag && cfg_ff inside {4'h8, 4'h9}
            |=> $signed(tlim_out.upper) >= $signed(RST_TQOFS);
    endproperty
    a_up_min: assert property (p_up_min) else $error("upper limit too low");
    property p_lo_max;
        overvoltage_ctrl_active_flag && cfg_ff inside {4'h7, 4'h9}
            |=> $signed(tlim_out.lower) <= $signed(RST_TQOFS);
    endproperty
    a_lo_max: assert property (p_lo_max) else $error("lower limit too high");
    c_ov: cover property ($rose(overvoltage_ctrl_active_flag));
    c_uv: cover property ($rose(undervoltage_ctrl_active_flag));
    c_trip: cover property ($rose(overvoltage_trip_fault));
endmodule // vdl_limiter_chk
bind vdl_limiter vdl_limiter_chk u_chk (.clk, .rst_n, .ctl_tick, .vdc, .tlim_out,
    .undervoltage_trip_fault, .overvoltage_trip_fault, .overvoltage_ctrl_active_flag,
    .undervoltage_ctrl_active_flag, .reg_addr, .reg_wdata, .reg_wr);
`default_nettype wire

//--- sim/testbench.sv
// Self-checking bench for the DC link voltage limiter.
// Assumes the link model ticks every 4 clocks; 10 clocks settle any change.
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import vdl_pkg::*;
    logic          clk, rst_n, ctl_tick, reg_wr, reg_rd, irq;
    logic          undervoltage_trip_fault, overvoltage_trip_fault;
    logic          overvoltage_ctrl_active_flag, undervoltage_ctrl_active_flag;
    logic [VW-1:0] vdc, level;
    logic [7:0]    reg_addr;
    logic [31:0]   reg_wdata, reg_rdata;
    vdl_tlim_t     tlim_in, tlim_out;
    int            err_total, comparisons;
    vdl_link_model u_link (.clk, .rst_n, .level, .ctl_tick, .vdc, .tlim_in);
    vdl_limiter u_dut (.clk, .rst_n, .ctl_tick, .vdc, .tlim_in, .tlim_out,
        .undervoltage_trip_fault, .overvoltage_trip_fault, .overvoltage_ctrl_active_flag,
        .undervoltage_ctrl_active_flag, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .irq);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // One access, then an idle cycle; read data are taken in the cycle after.
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk);
        q = reg_rdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, q);
        check(what, exp, q);
    endtask
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
    endtask
    // Reset values, a read-only write and an unmapped read.
    task automatic t_regs();
        rd_chk("config", OFS_CONFIG, 32'h0000_0000);
        rd_chk("upper", OFS_UPPER_THR, 32'h0000_02BC);
        rd_chk("lower", OFS_LOWER_THR, 32'h0000_01C2);
        rd_chk("gain", OFS_GAIN, 32'h0000_0100);
        wr(OFS_STATUS, 32'hFFFF_FFFF);
        rd_chk("status", OFS_STATUS, 32'h0000_0000);
        rd_chk("unmapped", 8'h24, 32'h0000_0000);
        rd_chk("offset", OFS_TQ_OFFSET, 32'h0000_0000);
        rd_chk("mask", OFS_IRQ_MASK, 32'h0000_0000);
        rd_chk("vdc", OFS_VDC, 32'h0000_0258);
    endtask
    // Holds one link level and judges flags, trips, status and limits.
    task automatic phase(input logic [3:0] c, input logic [15:0] lvl, input logic ova,
                         input logic uva, input logic ovt, input logic uvt, input int exc);
        int up, lo, corr;
        corr = (exc * 128) >>> 8;
        up = 20 + corr;
        lo = -20 + corr;
        if (uva && c inside {4'h8, 4'h9} && up < 0) up = 0;
        if (ova && c inside {4'h7, 4'h9} && lo > 0) lo = 0;
        level <= lvl;
        repeat (10) @(posedge clk);
        check("ov flag", 32'(ova), 32'(overvoltage_ctrl_active_flag));
        check("uv flag", 32'(uva), 32'(undervoltage_ctrl_active_flag));
        check("ov trip", 32'(ovt), 32'(overvoltage_trip_fault));
        check("uv trip", 32'(uvt), 32'(undervoltage_trip_fault));
        check("upper", 32'(up), 32'($signed(tlim_out.upper)));
        check("lower", 32'(lo), 32'($signed(tlim_out.lower)));
        rd_chk("status", OFS_STATUS, (32'(ova) << ST_OV_ACT) | (32'(uva) << ST_UV_ACT));
    endtask
    // Over, under and back to nominal for one mode code.
    task automatic t_mode(input logic [3:0] c);
        logic ov_en, uv_en, ovt, uvt;
        ov_en = c inside {4'h1, 4'h3, 4'h7, 4'h9};
        uv_en = c inside {4'h2, 4'h3, 4'h8, 4'h9};
        ovt = c inside {4'h4, 4'h6};
        uvt = c inside {4'h5, 4'h6};
        do_reset();
        wr(OFS_CONFIG, 32'(c));
        wr(OFS_UPPER_THR, 32'h0000_028A);  // Nominal 600 V plus 50 V.
        wr(OFS_LOWER_THR, 32'h0000_0226);  // Nominal 600 V less 50 V.
        wr(OFS_GAIN, 32'h0000_0080);       // Half of a 1 mF link.
        phase(c, 16'h02BC, ov_en, 1'b0, ovt, 1'b0, ov_en ? 50 : 0);
        phase(c, 16'h01F4, 1'b0, uv_en, ovt, uvt, uv_en ? -50 : 0);
        phase(c, 16'h0258, 1'b0, 1'b0, ovt, uvt, 0);
    endtask
    // Event at the exact default upper threshold, masked, enabled, cleared.
    task automatic t_irq();
        do_reset();
        wr(OFS_CONFIG, 32'h0000_0001);
        level <= 16'h02BC;
        repeat (10) @(posedge clk);
        check("irq masked", 32'h0000_0000, 32'(irq));
        rd_chk("irq stat", OFS_IRQ_STAT, 32'h0000_0008);
        wr(OFS_IRQ_MASK, 32'h0000_0008);
        @(posedge clk);
        check("irq", 32'h0000_0001, 32'(irq));
        wr(OFS_IRQ_STAT, 32'h0000_0008);
        @(posedge clk);
        check("irq cleared", 32'h0000_0000, 32'(irq));
        rd_chk("irq stat", OFS_IRQ_STAT, 32'h0000_0000);
    endtask
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        level = 16'h0258;
        do_reset();
        t_regs();
        for (int c = 0; c < 16; c++) begin
            t_mode(4'(c));
        end
        t_irq();
        tally_and_finish();
    end
    // A hang counts as a mismatch.
    initial begin
        #200_000;
        err_total++;
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
